/* vitb_pkg.sv */
// package: offsets, field positions, reset values and carriers for the virtual table base block
package vitb_pkg;
   // register offsets in the virtual frame (byte addresses)
   localparam logic [7:0] VITB_OFF_CFG_LO = 8'h70;
   localparam logic [7:0] VITB_OFF_CFG_HI = 8'h74;
   localparam logic [7:0] VITB_OFF_PEND_LO = 8'h78;
   localparam logic [7:0] VITB_OFF_PEND_HI = 8'h7c;
   // pending-table and config-table base field positions
   localparam int VITB_VALID_BIT = 63;
   localparam int VITB_IAI_BIT = 62;
   localparam int VITB_LAST_BIT = 61;
   localparam int VITB_DIRTY_BIT = 60;
   localparam int VITB_OUTER_LSB = 56;
   localparam int VITB_PADDR_MSB = 51;
   localparam int VITB_PEND_PADDR_LSB = 16;
   localparam int VITB_CFG_PADDR_LSB = 12;
   localparam int VITB_SHARE_LSB = 10;
   localparam int VITB_INNER_LSB = 7;
   localparam int VITB_IDBITS_LSB = 0;
   // values after reset
   localparam logic VITB_RST_VALID = 1'b0;
   localparam logic VITB_RST_LAST = 1'b0;
   localparam logic VITB_RST_DIRTY = 1'b0;
   localparam logic [2:0] VITB_RST_ATTR3 = 3'h0;
   localparam logic [1:0] VITB_RST_SHARE = 2'h0;
   // shareability codes
   localparam logic [1:0] VITB_SH_NON = 2'h0;
   localparam logic [1:0] VITB_SH_RSVD = 2'h3;
   // cycles from write to write-pending clear
   localparam int VITB_SETTLE_NS = 20;
   localparam int VITB_CLK_PS = 5000;
   localparam int VITB_SETTLE_CYC = (VITB_SETTLE_NS * 1000 + VITB_CLK_PS - 1) / VITB_CLK_PS;

   // memory attributes for table accesses
   typedef struct packed {
      logic [2:0] outer;
      logic [2:0] inner;
      logic [1:0] share;
   } vitb_attr_s;

   // register access port
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [31:0] wdata;
   } vitb_req_s;

   typedef enum logic [1:0] {VITB_IDLE, VITB_SCAN, VITB_DRAIN} vitb_state_e;
endpackage : vitb_pkg

/* vitb_settle.sv */
// settle timer: holds write-pending until a write is visible
`timescale 1ns/1ps
`default_nettype none
module vitb_settle
   import vitb_pkg::*;
#(
   parameter int CYCLES = VITB_SETTLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   output logic busy
);
   typedef struct packed {
      logic [7:0] cnt;
   } vitb_set_s;
   vitb_set_s st_r, st_nxt;

   // restart the count on every accepted pending-table write
   always_comb begin
      st_nxt = st_r;
      if (start) begin
         st_nxt.cnt = 8'(CYCLES);
      end else if (st_r.cnt != 8'h00) begin
         st_nxt.cnt = st_r.cnt - 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign busy = (st_r.cnt != 8'h00);
endmodule // vitb_settle
`default_nettype wire

/* vitb_regs.sv */
// virtual table base registers: scheduling, attributes and deschedule status
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - bit 63 valid schedules a virtual element
// R2 - software keeps other bits while valid
// R3 - valid, last-pending, dirty reset to zero
// R4 - bit 62 flags implementation area invalid
// R5 - descheduling captures pending-and-enabled into bit 61
// R6 - schedule with last clear: table is zero
// R7 - schedule with last set: read table
// R8 - bit 60 dirty shows uncompleted interrupts
// R9 - while invalid, clear CPU interface pending
// R10 - software waits for dirty clear
// R11 - no valid without virtual CPU support
// R12 - bits 58:56 outer cacheability code
// R13 - bits 9:7 inner cacheability code
// R14 - bits 11:10 shareability, 11 as 00
// R15 - attribute fields writable, reset unknown; this block resets them to zero
// R16 - software keeps attributes identical
// R17 - pending address bits 51:16, masked width
// R18 - config address bits 51:12, masked width
// R19 - config uses same attribute codings
// R20 - write-pending flag clears on completion
// R21 - last-pending set only for enabled pending
module vitb_regs
   import vitb_pkg::*;
#(
   parameter int PA_BITS = 52,
   parameter int SETTLE = VITB_SETTLE_CYC
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire vitb_req_s req,
   output logic [31:0] rdata,
   output logic rvalid,
   output logic write_pending_flag,
   input wire logic elem_pend_enabled,
   input wire logic elem_uncompleted,
   input wire logic cpu_pending_held,
   output logic cpu_release,
   output logic table_read_req,
   input wire logic table_read_done,
   output logic table_assume_zero,
   output logic elem_scheduled,
   output logic [51:0] pend_table_addr,
   output logic [51:0] cfg_table_addr,
   output vitb_attr_s pend_attr,
   output vitb_attr_s cfg_attr
);
   typedef struct packed {
      logic valid;
      logic iai;
      logic last;
      logic dirty;
      vitb_attr_s pattr;
      logic [51:16] paddr;
      vitb_attr_s cattr;
      logic [51:12] caddr;
      logic [4:0] idbits;
      logic [31:0] rdata;
      logic rvalid;
      logic zero;
      vitb_state_e state;
   } vitb_st_s;
   vitb_st_s st_r, st_nxt;
   logic settle_busy;
   logic [63:0] pend_view, cfg_view, pend_wr, cfg_wr;
   logic [51:0] pend_full, cfg_full;

   // mask address bits above implemented width
   function automatic logic [51:0] pa_mask(input logic [51:0] a);
      logic [51:0] m;
      m = '0;
      for (int i = 0; i < 52; i++) begin
         m[i] = (i < PA_BITS) ? a[i] : 1'b0;
      end
      return m;
   endfunction

   // reserved shareability code behaves as non-shareable
   function automatic logic [1:0] share_eff(input logic [1:0] s);
      return (s == VITB_SH_RSVD) ? VITB_SH_NON : s; // R14
   endfunction

   // full table addresses with unimplemented upper bits cleared
   assign pend_full = pa_mask({st_r.paddr, 16'h0000}); // R17
   assign cfg_full = pa_mask({st_r.caddr, 12'h000}); // R18

   // readback views of both registers
   always_comb begin
      pend_view = '0;
      pend_view[VITB_VALID_BIT] = st_r.valid; // R1
      pend_view[VITB_IAI_BIT] = st_r.iai; // R4
      pend_view[VITB_LAST_BIT] = st_r.last;
      pend_view[VITB_DIRTY_BIT] = st_r.dirty; // R8
      pend_view[VITB_OUTER_LSB +: 3] = st_r.pattr.outer; // R12
      pend_view[VITB_PADDR_MSB:VITB_PEND_PADDR_LSB] = pend_full[51:16]; // R17
      pend_view[VITB_SHARE_LSB +: 2] = st_r.pattr.share;
      pend_view[VITB_INNER_LSB +: 3] = st_r.pattr.inner; // R13
      cfg_view = '0;
      cfg_view[VITB_OUTER_LSB +: 3] = st_r.cattr.outer; // R19
      cfg_view[VITB_PADDR_MSB:VITB_CFG_PADDR_LSB] = cfg_full[51:12]; // R18
      cfg_view[VITB_SHARE_LSB +: 2] = st_r.cattr.share; // R19
      cfg_view[VITB_INNER_LSB +: 3] = st_r.cattr.inner;
      cfg_view[VITB_IDBITS_LSB +: 5] = st_r.idbits;
   end

   // merge a 32-bit write into the addressed half
   always_comb begin
      pend_wr = pend_view;
      cfg_wr = cfg_view;
      if (req.addr == VITB_OFF_PEND_LO) begin
         pend_wr[31:0] = req.wdata;
      end
      if (req.addr == VITB_OFF_PEND_HI) begin
         pend_wr[63:32] = req.wdata;
      end
      if (req.addr == VITB_OFF_CFG_LO) begin
         cfg_wr[31:0] = req.wdata;
      end
      if (req.addr == VITB_OFF_CFG_HI) begin
         cfg_wr[63:32] = req.wdata;
      end
   end

   // register writes, scheduling transitions and reads
   always_comb begin
      st_nxt = st_r;
      st_nxt.rvalid = req.rd;
      st_nxt.rdata = st_r.rdata;
      if (req.rd) begin
         case (req.addr)
            VITB_OFF_PEND_LO: st_nxt.rdata = pend_view[31:0];
            VITB_OFF_PEND_HI: st_nxt.rdata = pend_view[63:32];
            VITB_OFF_CFG_LO: st_nxt.rdata = cfg_view[31:0];
            VITB_OFF_CFG_HI: st_nxt.rdata = cfg_view[63:32];
            default: st_nxt.rdata = 32'h0000_0000;
         endcase
      end
      // dirty tracks uncompleted work only while descheduled
      st_nxt.dirty = ~st_r.valid & elem_uncompleted; // R8
      if (req.wr && (req.addr == VITB_OFF_CFG_LO || req.addr == VITB_OFF_CFG_HI)) begin
         st_nxt.cattr.outer = cfg_wr[VITB_OUTER_LSB +: 3]; // R15
         st_nxt.cattr.inner = cfg_wr[VITB_INNER_LSB +: 3];
         st_nxt.cattr.share = cfg_wr[VITB_SHARE_LSB +: 2];
         st_nxt.caddr = cfg_wr[VITB_PADDR_MSB:VITB_CFG_PADDR_LSB];
         st_nxt.idbits = cfg_wr[VITB_IDBITS_LSB +: 5];
      end
      if (req.wr && (req.addr == VITB_OFF_PEND_LO || req.addr == VITB_OFF_PEND_HI)) begin
         // other fields only change while descheduled, except last-pending on the deschedule write
         if (!st_r.valid) begin // R2
            st_nxt.iai = pend_wr[VITB_IAI_BIT]; // R4
            st_nxt.last = pend_wr[VITB_LAST_BIT];
            st_nxt.pattr.outer = pend_wr[VITB_OUTER_LSB +: 3]; // R15
            st_nxt.pattr.inner = pend_wr[VITB_INNER_LSB +: 3];
            st_nxt.pattr.share = pend_wr[VITB_SHARE_LSB +: 2];
            st_nxt.paddr = pend_wr[VITB_PADDR_MSB:VITB_PEND_PADDR_LSB];
         end
         st_nxt.valid = pend_wr[VITB_VALID_BIT]; // R1
         if (st_r.valid && !pend_wr[VITB_VALID_BIT]) begin
            st_nxt.last = elem_pend_enabled; // R5 R21
            st_nxt.state = VITB_DRAIN;
         end
         if (!st_r.valid && pend_wr[VITB_VALID_BIT]) begin
            // the last-pending value written decides a table scan
            if (pend_wr[VITB_LAST_BIT]) begin
               st_nxt.state = VITB_SCAN; // R7
               st_nxt.zero = 1'b0;
            end else begin
               st_nxt.state = VITB_IDLE; // R6
               st_nxt.zero = 1'b1;
            end
         end
      end else begin
         case (st_r.state)
            VITB_SCAN: if (table_read_done) st_nxt.state = VITB_IDLE;
            VITB_DRAIN: if (!cpu_pending_held) st_nxt.state = VITB_IDLE;
            VITB_IDLE: st_nxt.state = VITB_IDLE;
            default: st_nxt.state = VITB_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_r <= st_nxt;
         st_r.valid <= VITB_RST_VALID; // R3
         st_r.last <= VITB_RST_LAST;
         st_r.dirty <= VITB_RST_DIRTY;
         st_r.iai <= 1'b0;
         st_r.pattr <= '{VITB_RST_ATTR3, VITB_RST_ATTR3, VITB_RST_SHARE};
         st_r.cattr <= '{VITB_RST_ATTR3, VITB_RST_ATTR3, VITB_RST_SHARE};
         st_r.paddr <= '0;
         st_r.caddr <= '0;
         st_r.idbits <= 5'h00;
         st_r.rdata <= 32'h0000_0000;
         st_r.rvalid <= 1'b0;
         st_r.zero <= 1'b0;
         st_r.state <= VITB_IDLE;
      end else begin
         st_r <= st_nxt;
      end
   end

   // completion of pending-table writes
   vitb_settle #(.CYCLES(SETTLE)) u_settle (
      .core_clk(core_clk),
      .rst(rst),
      .start(req.wr && (req.addr == VITB_OFF_PEND_LO || req.addr == VITB_OFF_PEND_HI)),
      .busy(settle_busy)
   );

   // outputs to memory side and CPU interface
   assign write_pending_flag = settle_busy; // R20
   assign rdata = st_r.rdata;
   assign rvalid = st_r.rvalid;
   assign cpu_release = ~st_r.valid & cpu_pending_held; // R9
   assign table_read_req = st_r.valid & (st_r.state == VITB_SCAN); // R7
   assign table_assume_zero = st_r.valid & st_r.zero; // R6
   assign elem_scheduled = st_r.valid;
   assign pend_table_addr = pend_full;
   assign cfg_table_addr = cfg_full;
   assign pend_attr = '{st_r.pattr.outer, st_r.pattr.inner, share_eff(st_r.pattr.share)};
   assign cfg_attr = '{st_r.cattr.outer, st_r.cattr.inner, share_eff(st_r.cattr.share)};
endmodule // vitb_regs
`default_nettype wire

/* vitb_regs_chk.sv */
// assertion checker for the virtual table base registers
`timescale 1ns/1ps
`default_nettype none
module vitb_regs_chk
   import vitb_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire vitb_req_s req,
   input wire logic write_pending_flag,
   input wire logic cpu_pending_held,
   input wire logic cpu_release,
   input wire logic table_read_req,
   input wire logic table_read_done,
   input wire logic table_assume_zero,
   input wire logic elem_scheduled,
   input wire vitb_attr_s pend_attr
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   logic hi_wr;
   // write to the upper pending word
   assign hi_wr = req.wr && req.addr == VITB_OFF_PEND_HI;
   sched_set_a: assert property (hi_wr && req.wdata[31] |=> elem_scheduled)
      else $error("valid bit not set");
   sched_clr_a: assert property (hi_wr && !req.wdata[31] |=> !elem_scheduled)
      else $error("valid bit not cleared");
   zero_table_a: assert property (hi_wr && req.wdata[31] && !req.wdata[29] && !elem_scheduled
      |=> table_assume_zero && !table_read_req) else $error("zero table not assumed");
   scan_table_a: assert property (hi_wr && req.wdata[31] && req.wdata[29] && !elem_scheduled
      |=> table_read_req && !table_assume_zero) else $error("table read not started");
   scan_end_a: assert property (table_read_req && table_read_done |-> ##[1:2] !table_read_req)
      else $error("table read not ended");
   cpu_release_a: assert property (cpu_release == (!elem_scheduled && cpu_pending_held))
      else $error("release wrong");
   settle_len_a: assert property ($rose(write_pending_flag) |-> write_pending_flag [*4] ##1 !write_pending_flag)
      else $error("settle length wrong");
   settle_start_a: assert property (hi_wr |=> write_pending_flag)
      else $error("write pending not raised");
   share_out_a: assert property (pend_attr.share != VITB_SH_RSVD)
      else $error("reserved share driven");
endmodule // vitb_regs_chk
`default_nettype wire

/* tb_virtual_interrupt_table_base.sv */
// self-checking bench for the virtual table base registers
`timescale 1ns/1ps
`default_nettype none
module tb_virtual_interrupt_table_base;
   import vitb_pkg::*;
   logic core_clk, rst, rvalid, write_pending_flag, cpu_release, table_read_req, table_assume_zero;
   logic elem_scheduled, elem_pend_enabled, elem_uncompleted, cpu_pending_held, table_read_done;
   logic [31:0] rdata, d;
   logic [51:0] pend_table_addr, cfg_table_addr;
   vitb_req_s req;
   vitb_attr_s pend_attr, cfg_attr;
   int err_count, samples_checked, n;

   vitb_regs #(.PA_BITS(52), .SETTLE(4)) i_dut (.core_clk, .rst, .req, .rdata, .rvalid, .write_pending_flag,
      .elem_pend_enabled, .elem_uncompleted, .cpu_pending_held, .cpu_release, .table_read_req,
      .table_read_done, .table_assume_zero, .elem_scheduled, .pend_table_addr, .cfg_table_addr,
      .pend_attr, .cfg_attr);

   // 200 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // one write, then wait out write-pending, n counts its cycles
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      #1 req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
      @(posedge core_clk);
      #1 req.wr = 1'b0;
      n = 0;
      while (write_pending_flag && n < 20) begin
         @(posedge core_clk);
         #1 n++;
      end
   endtask

   // one read, answer judged one cycle later
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge core_clk);
      #1 req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge core_clk);
      #1 req.rd = 1'b0;
      chk(rvalid, 1'b1);
      chk(rdata, e);
   endtask

   task automatic t_reset;
      chk(write_pending_flag, 1'b0);
      rd(VITB_OFF_PEND_HI, 32'h0000_0000);
      rd(8'h40, 32'h0000_0000);
   endtask

   // every attribute code, reserved bits dropped
   task automatic t_pend_attr;
      for (int i = 0; i < 8; i++) begin
         d = {16'hABCD, 4'h0, i[1:0], i[2:0], 7'h00};
         wr(VITB_OFF_PEND_LO, d | 32'h0000_F07F);
         rd(VITB_OFF_PEND_LO, d);
         wr(VITB_OFF_PEND_HI, {4'h5, 1'b0, i[2:0], 4'hF, 20'h1_2345});
         rd(VITB_OFF_PEND_HI, {4'h4, 1'b0, i[2:0], 24'h01_2345});
         chk(pend_attr, {i[2:0], i[2:0], (i[1:0] == 2'h3) ? 2'h0 : i[1:0]});
         chk(pend_table_addr, {20'h1_2345, 16'hABCD, 16'h0000});
      end
   endtask

   task automatic t_cfg;
      wr(VITB_OFF_CFG_LO, 32'h9876_5FEC);
      wr(VITB_OFF_CFG_HI, 32'hFD0A_BCDE);
      rd(VITB_OFF_CFG_LO, 32'h9876_5F8C);
      rd(VITB_OFF_CFG_HI, 32'h050A_BCDE);
      chk(cfg_attr, 8'hBC);
      chk(cfg_table_addr, {20'hABCDE, 20'h98765, 12'h000});
   endtask

   // schedule, deschedule, then schedule with table scan
   task automatic t_sched;
      cpu_pending_held = 1'b1;
      elem_pend_enabled = 1'b1;
      elem_uncompleted = 1'b1;
      #1 chk(cpu_release, 1'b1);
      wr(VITB_OFF_PEND_HI, 32'h8000_0000);
      chk(n, 4);
      chk({elem_scheduled, table_assume_zero, table_read_req, cpu_release}, 4'hC);
      wr(VITB_OFF_PEND_HI, 32'h0000_0000);
      chk({elem_scheduled, cpu_release}, 2'h1);
      rd(VITB_OFF_PEND_HI, 32'h3000_0000);
      elem_pend_enabled = 1'b0;
      elem_uncompleted = 1'b0;
      // dirty clears one edge before the write is taken
      wr(VITB_OFF_PEND_HI, 32'hA000_0000);
      chk({table_read_req, table_assume_zero}, 2'h2);
      @(posedge core_clk);
      #1 table_read_done = 1'b1;
      @(posedge core_clk);
      #1 table_read_done = 1'b0;
      @(posedge core_clk);
      #1 chk(table_read_req, 1'b0);
      // the valid and last-pending bits both differ from what is stored
      wr(VITB_OFF_PEND_HI, 32'h0000_0000);
      rd(VITB_OFF_PEND_HI, 32'h0000_0000);
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      #20000;
      err_count++;
      print_verdict();
   end

   // main sequence
   initial begin
      err_count = 0;
      samples_checked = 0;
      rst = 1'b1;
      req = '0;
      elem_pend_enabled = 1'b0;
      elem_uncompleted = 1'b0;
      cpu_pending_held = 1'b0;
      table_read_done = 1'b0;
      repeat (6) @(posedge core_clk);
      #1 rst = 1'b0;
      t_reset();
      t_pend_attr();
      t_cfg();
      t_sched();
      print_verdict();
   end
endmodule // tb_virtual_interrupt_table_base

bind vitb_regs vitb_regs_chk i_chk (.core_clk, .rst, .req, .write_pending_flag, .cpu_pending_held,
   .cpu_release, .table_read_req, .table_read_done, .table_assume_zero, .elem_scheduled, .pend_attr);
`default_nettype wire
